// ---- core/slr_pkg.sv ----
// switch line re-sync package: constants, modes and carrier structs
// assumes a 20 MHz pixel-side clock and line numbers counted from 1
package slr_pkg;

    // ==========================================================
    // clock and phase limit
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned PHASE_LIMIT_US  = 10;
    // longest time, so round down; never below one cycle
    localparam int unsigned PHASE_LIMIT_RAW = (PHASE_LIMIT_US * (CLK_HZ / 1_000_000));
    localparam logic [11:0] PHASE_LIMIT_CYC =
        12'(PHASE_LIMIT_RAW < 1 ? 1 : PHASE_LIMIT_RAW);

    // ==========================================================
    // widths
    localparam int LINE_W  = 11;
    localparam int PHASE_W = 12;

    // ==========================================================
    // switch lines, first and second field
    localparam logic [10:0] SW_525_F1  = 11'h00a;
    localparam logic [10:0] SW_525_F2  = 11'h111;
    localparam logic [10:0] SW_625_F1  = 11'h006;
    localparam logic [10:0] SW_625_F2  = 11'h13f;
    localparam logic [10:0] SW_750_F1  = 11'h007;
    localparam logic [10:0] SW_1125_F1 = 11'h007;
    localparam logic [10:0] SW_1125_F2 = 11'h238;
    localparam logic [10:0] SW_NONE    = 11'h000;

    // ==========================================================
    // detected line structure
    typedef enum logic [1:0] {
        LINES_525,
        LINES_625,
        LINES_750,
        LINES_1125
    } slr_lines_t;

    // detected standard from the standards detector
    typedef struct packed {
        logic       valid;
        slr_lines_t lines;
        logic       interlaced;
        logic       psf;
        logic       rate24;
        logic       pid_present;
    } slr_std_t;

    // timing reference tracking events
    typedef struct packed {
        logic              line_end;
        logic              trs_id;
        logic              in_active;
        logic [LINE_W-1:0] line_num;
    } slr_sync_t;

    // level b to level a conversion status
    typedef struct packed {
        logic               conv_en;
        logic               extended;
        logic [PHASE_W-1:0] phase_cyc;
    } slr_conv_t;

endpackage

// ---- core/slr_switch_line_resync.sv ----
// switch line re-sync: decides when word alignment and timing generator
// re-align, automatically on the switch line or on the manual strobe.
// assumes all inputs synchronous to clk, line_end and trs_id one-cycle
// pulses from the trs tracker, line_num valid while line_end is high.
//
// How it works
// R1: realign automatically at the switch point chosen from the detected standard
// R2: automatic realign once per field interlaced, once per frame progressive
// R3: 525 interlaced realigns at end of lines 10 and 273
// R4: 525 progressive realigns at end of line 10
// R5: 625 interlaced realigns at end of lines 6 and 319
// R6: 625 progressive realigns at end of line 6
// R7: 750 progressive realigns at end of line 7
// R8: 1125 interlaced realigns at end of lines 7 and 568
// R9: 1125 progressive, psf included, realigns at end of line 7
// R10: without payload id, 1125 psf at 25 or 30 treated as interlaced
// R11: 1125 psf at 24 frames is its own format, not interlaced
// R12: conversion with extended active: realign on next trs id if phase within 10 us
// R13: same case with phase beyond 10 us takes one extra line
// R14: during that extra line the h blanking pulse may be omitted
// R15: phase limit only under conversion with extended active period
// R16: switch line handling works only while processing select is high
// R17: rising manual strobe within active line forces realign on next trs word
// R18: controller keeps manual strobe low except about one line on switch
// R19: no detected standard means no automatic realign
`timescale 1ns/100ps

module slr_switch_line_resync
(
    // clock, reset, enable
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // mode and detection
    input  wire logic              processing_select,
    input  wire slr_pkg::slr_std_t std_in,
    input  wire slr_pkg::slr_conv_t conv_in,
    // timing reference events
    input  wire slr_pkg::slr_sync_t sync_in,
    // manual switch
    input  wire logic              manual_switch_strobe,
    // results
    output logic                   resync,
    output logic                   resync_auto,
    output logic                   h_omit,
    output logic                   wait_extra
);

    // ==========================================================
    // reset release
    logic rst_meta;
    logic rst_sync;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ==========================================================
    // switch line lookup
    function automatic logic [10:0] sw_line(input slr_pkg::slr_lines_t l,
                                            input logic second);
        logic [10:0] r;
        r = slr_pkg::SW_NONE;
        case (l)
            // R3: 525 lines
            slr_pkg::LINES_525:  r = second ? slr_pkg::SW_525_F2  : slr_pkg::SW_525_F1;
            // R5: 625 lines
            slr_pkg::LINES_625:  r = second ? slr_pkg::SW_625_F2  : slr_pkg::SW_625_F1;
            // R7: 750 lines, progressive only
            slr_pkg::LINES_750:  r = second ? slr_pkg::SW_NONE    : slr_pkg::SW_750_F1;
            // R8: 1125 lines
            slr_pkg::LINES_1125: r = second ? slr_pkg::SW_1125_F2 : slr_pkg::SW_1125_F1;
            default:             r = slr_pkg::SW_NONE;
        endcase
        return r;
    endfunction

    // ==========================================================
    // scan classification
    logic eff_interlaced;
    logic psf_as_int;

    // R10: 25/30 psf without payload id looks interlaced
    // R11: 24 frame psf kept apart as progressive
    assign psf_as_int = std_in.psf && !std_in.pid_present && !std_in.rate24
                        && (std_in.lines == slr_pkg::LINES_1125);
    // R9: psf otherwise runs on the progressive switch line
    assign eff_interlaced = (std_in.interlaced && !std_in.psf) || psf_as_int;

    // ==========================================================
    // switch line hit
    logic at_switch;
    logic hit_f1;
    logic hit_f2;

    // R2: second field line only checked for interlaced scan
    // R4: R6: progressive uses only the first line
    assign hit_f1 = sync_in.line_num == sw_line(std_in.lines, 1'b0);
    assign hit_f2 = eff_interlaced && (sync_in.line_num == sw_line(std_in.lines, 1'b1));
    // R1: R19: R16: automatic only with valid standard in processing mode
    assign at_switch = processing_select && std_in.valid && sync_in.line_end
                       && (hit_f1 || hit_f2);

    // R15: phase limit applies only under conversion with extended active
    logic conv_case;
    logic over_limit;

    assign conv_case  = conv_in.conv_en && conv_in.extended;
    assign over_limit = conv_in.phase_cyc > slr_pkg::PHASE_LIMIT_CYC;

    // ==========================================================
    // manual strobe edge
    logic strobe_q;
    logic manual_pend;
    logic manual_rise;

    // R17: sampled each clk_en cycle, edge counted only inside active line
    assign manual_rise = manual_switch_strobe && !strobe_q && sync_in.in_active
                         && processing_select;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            strobe_q <= 1'b0;
        else if (!rst_sync)
            strobe_q <= 1'b0;
        else if (clk_en)
            strobe_q <= manual_switch_strobe;
    end

    // R17: pending until next trs word; a new edge wins over the clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            manual_pend <= 1'b0;
        else if (!rst_sync)
            manual_pend <= 1'b0;
        else if (clk_en)
        begin
            if (!processing_select)
                manual_pend <= 1'b0;
            else if (manual_rise)
                manual_pend <= 1'b1;
            else if (sync_in.trs_id)
                manual_pend <= 1'b0;
        end
    end

    // ==========================================================
    // automatic re-sync sequencing
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_TRS,
        ST_WAIT_LINE
    } slr_state_t;

    slr_state_t state;
    slr_state_t next_state;
    logic       next_auto_fire;

    always_comb
    begin
        next_state     = state;
        next_auto_fire = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (at_switch)
                begin
                    if (!conv_case)
                        // R1: normal case realigns at end of switch line
                        next_auto_fire = 1'b1;
                    else if (!over_limit)
                        // R12: within limit, next trs id
                        next_state = ST_WAIT_TRS;
                    else
                        // R13: beyond limit, one more line first
                        next_state = ST_WAIT_LINE;
                end
            end
            ST_WAIT_TRS:
            begin
                if (sync_in.trs_id)
                begin
                    next_auto_fire = 1'b1;
                    next_state     = ST_IDLE;
                end
            end
            ST_WAIT_LINE:
            begin
                // R13: extra line ends, then re-align on the next id
                if (sync_in.line_end)
                    next_state = ST_WAIT_TRS;
            end
            default:
                next_state = ST_IDLE;
        endcase
        // R16: leaving processing mode drops any pending sequence
        if (!processing_select)
        begin
            next_state     = ST_IDLE;
            next_auto_fire = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= ST_IDLE;
        else if (!rst_sync)
            state <= ST_IDLE;
        else if (clk_en)
            state <= next_state;
    end

    // ==========================================================
    // outputs, all registered
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            resync      <= 1'b0;
            resync_auto <= 1'b0;
            h_omit      <= 1'b0;
            wait_extra  <= 1'b0;
        end
        else if (!rst_sync)
        begin
            resync      <= 1'b0;
            resync_auto <= 1'b0;
            h_omit      <= 1'b0;
            wait_extra  <= 1'b0;
        end
        else if (clk_en)
        begin
            // R17: manual request fires on the next trs word
            resync      <= next_auto_fire
                           || (manual_pend && sync_in.trs_id && processing_select);
            resync_auto <= next_auto_fire;
            // R14: h pulse dropped over the extra line
            h_omit      <= next_state == ST_WAIT_LINE;
            wait_extra  <= next_state != ST_IDLE;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync || !clk_en);

    AST_MODE_GATE: assert property ( // R16
        resync |-> $past(processing_select))
        else $error("re-sync outside processing mode");

    AST_NO_STD: assert property ( // R19
        (state == ST_IDLE && !std_in.valid) |=> !resync_auto)
        else $error("automatic re-sync without a detected standard");

    AST_525_F2: assert property ( // R3
        (state == ST_IDLE && processing_select && std_in.valid && sync_in.line_end
         && std_in.lines == slr_pkg::LINES_525 && std_in.interlaced && !std_in.psf
         && sync_in.line_num == 11'h111 && !conv_case) |=> resync_auto)
        else $error("525 interlaced second field switch line missed");

    AST_625_F2: assert property ( // R5
        (state == ST_IDLE && processing_select && std_in.valid && sync_in.line_end
         && std_in.lines == slr_pkg::LINES_625 && std_in.interlaced && !std_in.psf
         && sync_in.line_num == 11'h13f && !conv_case) |=> resync_auto)
        else $error("625 interlaced second field switch line missed");

    AST_1125_F2: assert property ( // R8
        (state == ST_IDLE && processing_select && std_in.valid && sync_in.line_end
         && std_in.lines == slr_pkg::LINES_1125 && eff_interlaced
         && sync_in.line_num == 11'h238 && !conv_case) |=> resync_auto)
        else $error("1125 interlaced second field switch line missed");

    AST_PSF24: assert property ( // R11
        (state == ST_IDLE && sync_in.line_end && std_in.lines == slr_pkg::LINES_1125
         && std_in.psf && std_in.rate24 && sync_in.line_num == 11'h238)
        |=> !resync_auto)
        else $error("24 frame psf treated as interlaced");

    AST_EXTRA_LINE: assert property ( // R13
        (state == ST_IDLE && at_switch && conv_case && over_limit)
        |=> (!resync_auto && h_omit) ##1 (state == ST_WAIT_LINE))
        else $error("over-limit phase did not wait an extra line");

    AST_WITHIN_LIMIT: assert property ( // R12
        (state == ST_IDLE && at_switch && conv_case && !over_limit)
        |=> !resync_auto && !h_omit)
        else $error("within-limit phase wrongly delayed or fired");

    AST_MANUAL: assert property ( // R17
        (manual_rise && !sync_in.trs_id) ##1 (sync_in.trs_id && processing_select)
        |=> resync)
        else $error("manual strobe edge did not realign on next trs word");

    AST_MANUAL_WAIT: assert property ( // R17
        (manual_rise && !sync_in.trs_id)
        ##1 (processing_select && !sync_in.trs_id)[*5]
        ##1 (sync_in.trs_id && processing_select) |=> resync)
        else $error("held manual request did not realign on the trs word");

endmodule // slr_switch_line_resync

// ---- verification/slr_video_source.sv ----
// upstream source model: one video line per request, then a trs id
// assumes requests only while busy is low, go driven on rising clk
`timescale 1ns/100ps

module slr_video_source
(
    // clock
    input  wire logic          clk,
    // request
    input  wire logic          go,
    input  wire logic [10:0]   line_no,
    // stream
    output slr_pkg::slr_sync_t sync,
    output logic               busy
);
    // ==========================================================
    // line sequence
    initial
    begin
        sync = '0;
        busy = 1'b0;
    end

    always
    begin
        @(posedge clk);
        if (go)
        begin
            busy           <= 1'b1;
            sync.in_active <= 1'b1;
            repeat (4) @(posedge clk);
            sync.in_active <= 1'b0;
            sync.line_end  <= 1'b1;
            sync.line_num  <= line_no;
            @(posedge clk);
            // number not held after the pulse, so show its inverse
            sync.line_end  <= 1'b0;
            sync.line_num  <= ~line_no;
            repeat (2) @(posedge clk);
            sync.trs_id    <= 1'b1;
            @(posedge clk);
            sync.trs_id    <= 1'b0;
            busy           <= 1'b0;
        end
    end
endmodule // slr_video_source

// ---- verification/slr_switch_line_resync_bench.sv ----
// bench for the switch line re-sync block, scenario tasks
// assumes the source model and one 20 MHz clock
`timescale 1ns/100ps

module slr_switch_line_resync_bench;
    logic               clk, rst_n, clk_en, psel, strobe, go, busy;
    logic               resync, resync_auto, h_omit, wait_extra;
    logic [10:0]        line_no;
    slr_pkg::slr_std_t  std_in;
    slr_pkg::slr_conv_t conv_in;
    slr_pkg::slr_sync_t sync;
    logic [7:0]         n_rs, n_au, n_ho, n_wx, d_rs, d_au, d_ho, d_wx;
    int                 bad_count, cmp_count, cycles;

    // ==========================================================
    // instances
    slr_switch_line_resync i_slr_switch_line_resync (.clk(clk), .rst_n(rst_n),
        .clk_en(clk_en), .processing_select(psel), .std_in(std_in), .conv_in(conv_in),
        .sync_in(sync), .manual_switch_strobe(strobe), .resync(resync),
        .resync_auto(resync_auto), .h_omit(h_omit), .wait_extra(wait_extra));
    slr_video_source i_slr_video_source (.clk(clk), .go(go), .line_no(line_no),
        .sync(sync), .busy(busy));

    // ==========================================================
    // clock, event counters, timeout
    initial
    begin
        {clk, rst_n, strobe, go, line_no, std_in, conv_in} = '0;
        {n_rs, n_au, n_ho, n_wx} = '0;
        {clk_en, psel} = 2'h3;
        {bad_count, cmp_count, cycles} = '0;
    end
    always #25 clk = ~clk;

    // resync pulses and h_omit/wait_extra levels counted in each cycle they stand high
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (resync === 1'b1) n_rs <= n_rs + 8'h01;
        if (resync_auto === 1'b1) n_au <= n_au + 8'h01;
        if (h_omit === 1'b1) n_ho <= n_ho + 8'h01;
        if (wait_extra === 1'b1) n_wx <= n_wx + 8'h01;
        if (cycles == 5000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic slr_pkg::slr_std_t sd(input slr_pkg::slr_lines_t l,
        input logic il, input logic ps, input logic r24, input logic pid);
        return '{1'b1, l, il, ps, r24, pid};
    endfunction

    // sm: bit0 strobe rises inside the line, bit1 strobe already high before it
    task automatic line(input slr_pkg::slr_std_t s, input logic [10:0] ln,
        input logic [1:0] sm);
        logic [7:0] r0, a0, h0, w0;
        int n;
        {r0, a0, h0, w0} = {n_rs, n_au, n_ho, n_wx};
        n = 0;
        std_in <= s;
        line_no <= ln;
        strobe <= sm[1];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        strobe <= |sm;
        while (busy === 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
        // strobe dropped after about one line
        strobe <= 1'b0;
        @(posedge clk);
        {d_rs, d_au, d_ho, d_wx} = {n_rs - r0, n_au - a0, n_ho - h0, n_wx - w0};
    endtask

    task automatic auto_case(input slr_pkg::slr_std_t s, input logic [10:0] ln,
        input logic [7:0] e);
        line(s, ln, 2'h0);
        chk(d_rs, e);
        chk(d_au, e);
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        auto_case(sd(slr_pkg::LINES_525, 1, 0, 0, 0), 11'h00a, 8'h01);
        auto_case(sd(slr_pkg::LINES_525, 1, 0, 0, 0), 11'h111, 8'h01);
        auto_case(sd(slr_pkg::LINES_525, 1, 0, 0, 0), 11'h00b, 8'h00);
        auto_case(sd(slr_pkg::LINES_525, 0, 0, 0, 0), 11'h00a, 8'h01);
        auto_case(sd(slr_pkg::LINES_525, 0, 0, 0, 0), 11'h111, 8'h00);
        auto_case(sd(slr_pkg::LINES_625, 1, 0, 0, 0), 11'h006, 8'h01);
        auto_case(sd(slr_pkg::LINES_625, 1, 0, 0, 0), 11'h13f, 8'h01);
        auto_case(sd(slr_pkg::LINES_625, 1, 0, 0, 0), 11'h007, 8'h00);
        auto_case(sd(slr_pkg::LINES_625, 0, 0, 0, 0), 11'h006, 8'h01);
        auto_case(sd(slr_pkg::LINES_625, 0, 0, 0, 0), 11'h13f, 8'h00);
        auto_case(sd(slr_pkg::LINES_750, 0, 0, 0, 0), 11'h007, 8'h01);
        auto_case(sd(slr_pkg::LINES_750, 0, 0, 0, 0), 11'h238, 8'h00);
        auto_case(sd(slr_pkg::LINES_1125, 1, 0, 0, 0), 11'h007, 8'h01);
        auto_case(sd(slr_pkg::LINES_1125, 1, 0, 0, 0), 11'h238, 8'h01);
        auto_case(sd(slr_pkg::LINES_1125, 1, 0, 0, 0), 11'h239, 8'h00);
        auto_case(sd(slr_pkg::LINES_1125, 0, 0, 0, 0), 11'h007, 8'h01);
        auto_case(sd(slr_pkg::LINES_1125, 0, 0, 0, 0), 11'h238, 8'h00);
        auto_case(sd(slr_pkg::LINES_1125, 0, 1, 0, 0), 11'h238, 8'h01);
        auto_case(sd(slr_pkg::LINES_1125, 0, 1, 0, 1), 11'h238, 8'h00);
        auto_case(sd(slr_pkg::LINES_1125, 0, 1, 1, 0), 11'h238, 8'h00);
        auto_case(sd(slr_pkg::LINES_1125, 0, 1, 1, 0), 11'h007, 8'h01);
        auto_case('0, 11'h00a, 8'h00);
        psel <= 1'b0;
        auto_case(sd(slr_pkg::LINES_525, 1, 0, 0, 0), 11'h00a, 8'h00);
        psel <= 1'b1;
        // conversion with extended active, phase at the limit
        conv_in <= '{1'b1, 1'b1, 12'h0c8};
        line(sd(slr_pkg::LINES_1125, 1, 0, 0, 0), 11'h007, 2'h0);
        chk(d_rs, 8'h01);
        chk(8'(d_wx != 8'h00), 8'h01);
        chk(d_ho, 8'h00);
        // one cycle over the limit needs the extra line
        conv_in <= '{1'b1, 1'b1, 12'h0c9};
        line(sd(slr_pkg::LINES_1125, 1, 0, 0, 0), 11'h007, 2'h0);
        chk(d_rs, 8'h00);
        chk(8'(d_ho != 8'h00), 8'h01);
        line(sd(slr_pkg::LINES_1125, 1, 0, 0, 0), 11'h008, 2'h0);
        chk(d_au, 8'h01);
        chk(8'(h_omit), 8'h00);
        conv_in <= '{1'b1, 1'b0, 12'h0c9};
        line(sd(slr_pkg::LINES_1125, 1, 0, 0, 0), 11'h007, 2'h0);
        chk(d_rs, 8'h01);
        chk(d_wx, 8'h00);
        conv_in <= '0;
        line('0, 11'h064, 2'h1);
        chk(d_rs, 8'h01);
        chk(d_au, 8'h00);
        line('0, 11'h064, 2'h3);
        chk(d_rs, 8'h00);
        give_verdict();
    end
endmodule // slr_switch_line_resync_bench
